/* File: cctx_pkg.sv */
/*
  Shared constants for the composite clock transmitter: clock and line
  rates, derived cycle counts, frame geometry, register offsets, field
  positions, reset values and bus response codes.
  Assumes a single 200 MHz clock and a 32-bit AXI4-Lite register port.
*/
`default_nettype none
package cctx_pkg;
  // ==========================================================
  // Timing
  localparam int unsigned CLK_HZ = 200_000_000;          // System clock rate
  localparam int unsigned LINE_HZ = 64_000;              // Nominal line rate
  localparam int unsigned BIT_CYC = CLK_HZ / LINE_HZ;    // Bit period, 3125 cycles
  localparam int unsigned HALF_CYC = BIT_CYC / 2;        // 50% mark, rounded down
  localparam int unsigned FIVE8_CYC = (BIT_CYC * 5) / 8; // 5/8 mark, rounded down
  localparam int unsigned CNT_W = $clog2(BIT_CYC);       // Bit timer width
  // ==========================================================
  // Frame geometry
  localparam int unsigned BITS_PER_BPV = 8;              // One violation per 8 bits
  localparam int unsigned CYC_PER_400 = 160;             // One removed violation per 160
  localparam int unsigned FRAMES_400 = CYC_PER_400 / BITS_PER_BPV; // 20 frames
  localparam logic [2:0] VIOL_SLOT = 3'h7;               // Bit index carrying the violation
  localparam logic [4:0] REMOVE_FRAME = 5'h13;           // Frame whose violation is dropped
  // ==========================================================
  // Registers
  localparam int unsigned ADDR_W = 4;
  localparam logic [3:0] ADDR_CTRL = 4'h0;               // Control register
  localparam logic [3:0] ADDR_STATUS = 4'h4;             // Status register
  localparam int unsigned CTRL_EN_BIT = 0;               // Output enable
  localparam int unsigned CTRL_DUTY_BIT = 1;             // 1 = 5/8 duty, 0 = 50%
  localparam int unsigned CTRL_NO8_BIT = 2;              // Suppress 8 kHz component
  localparam int unsigned CTRL_400_BIT = 3;              // Enable 400 Hz component
  localparam logic [3:0] CTRL_RST = 4'h0;                // Control reset value
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;
endpackage : cctx_pkg
`default_nettype wire

/* File: cctx_if.sv */
/*
  Internal carrier between the bit timer, the frame sequencer and the
  line encoder of the composite clock transmitter.
  Assumes all three sit on the same clock.
*/
`timescale 1ns/100ps
`default_nettype none
interface cctx_if;
  logic bit_start;    // Pulse: a new bit period begins
  logic mark_on;      // Level: inside the mark part of the bit
  logic restart;      // Pulse: realign bit timing to the reference
  logic viol_slot;    // Level: the starting bit is a violation slot
  logic removed_slot; // Level: the starting bit is the 400 Hz removal slot
  logic [2:0] bit_idx;
  modport timer_mp(output bit_start, output mark_on, input restart);
  modport seq_mp(input bit_start, output viol_slot, output removed_slot, output bit_idx);
  modport top_mp(input bit_start, input mark_on, output restart, input viol_slot,
    input removed_slot, input bit_idx);
endinterface : cctx_if
`default_nettype wire

/* File: cctx_bit_timer.sv */
/*
  Bit timer: divides the system clock to the 64 kHz bit rate and marks
  the mark window of each bit at the selected duty cycle.
  Assumes restart pulses come from the reference alignment logic.
*/
`timescale 1ns/100ps
`default_nettype none
module cctx_bit_timer
  import cctx_pkg::*;
(
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic duty_58,
  cctx_if.timer_mp tif
);
  // ==========================================================
  // Divider
  logic [CNT_W-1:0] cnt_reg;  // Position inside the bit
  logic [CNT_W-1:0] cnt_next;
  logic [CNT_W-1:0] width;    // Mark length in cycles
  logic last_cyc;

  assign last_cyc = (cnt_reg == CNT_W'(BIT_CYC - 1));
  // Restart forces the next cycle to be a bit start
  assign cnt_next = (tif.restart || last_cyc) ? '0 : cnt_reg + CNT_W'(1);
  assign tif.bit_start = (cnt_reg == '0);
  // Duty select picks the mark length; 5/8 is the long form
  assign width = duty_58 ? CNT_W'(FIVE8_CYC) : CNT_W'(HALF_CYC); // R3
  // Return to zero after the mark window
  assign tif.mark_on = (cnt_reg < width); // R5

  // Counter register
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      cnt_reg <= '0;
    end else begin
      cnt_reg <= cnt_next; // R4
    end
  end
endmodule : cctx_bit_timer
`default_nettype wire

/* File: cctx_frame_seq.sv */
/*
  Frame sequencer: counts bits into 8-bit violation frames and frames
  into the 160-bit 400 Hz pattern, with loads for reference alignment.
  Assumes align pulses already qualified by reference state.
*/
`timescale 1ns/100ps
`default_nettype none
module cctx_frame_seq
  import cctx_pkg::*;
(
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic align_8k,
  input wire logic align_400,
  cctx_if.seq_mp sif
);
  // ==========================================================
  // Counters
  logic [2:0] bit_idx_reg;   // Bit index of the upcoming bit
  logic [4:0] frame_reg;     // Frame index inside the 400 Hz pattern
  logic frame_end;

  assign frame_end = (bit_idx_reg == VIOL_SLOT);
  assign sif.bit_idx = bit_idx_reg;
  // Violation once every eight bits
  assign sif.viol_slot = frame_end; // R12
  // Local 400 Hz pattern is divided from the 8 kHz frames
  assign sif.removed_slot = frame_end && (frame_reg == REMOVE_FRAME); // R10

  // Advance on bit start; alignment loads win since they point at the next bit
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      bit_idx_reg <= '0;
      frame_reg <= '0;
    end else if (align_400) begin
      bit_idx_reg <= VIOL_SLOT; // R9
      frame_reg <= REMOVE_FRAME;
    end else if (align_8k) begin
      bit_idx_reg <= VIOL_SLOT; // R7
    end else if (sif.bit_start) begin
      bit_idx_reg <= bit_idx_reg + 3'h1;
      if (frame_end) begin
        frame_reg <= (frame_reg == REMOVE_FRAME) ? 5'h0 : frame_reg + 5'h1;
      end
    end
  end
endmodule : cctx_frame_seq
`default_nettype wire

/* File: cctx_top.sv */
/*
  Composite clock transmitter top: AXI4-Lite control and status, AMI
  return-to-zero encoder with 8 kHz violations and 400 Hz removals,
  reference alignment and the differential output pin pair.
  Assumes reference status inputs are synchronous to aclk and that the
  line driver outside honours the output enables.
*/
// Contract
// [R1] Positive marks on one pin, negative on other
// [R2] One enable bit drives both pin enables
// [R3] Mark lasts half or five eighths of bit
// [R4] Line rate 64 kHz carrying 8 kHz violations
// [R5] AMI line code with return-to-zero pulses
// [R6] Suppress bit removes all violations
// [R7] Align violations to composite reference violations
// [R8] 400 Hz enable drops one violation per 160
// [R9] Align 400 Hz pattern to reference pattern
// [R10] Else derive 400 Hz from own violations
// [R11] 400 Hz enable ignored while violations suppressed
// [R12] One violation every eight bits
// [R13] Marks alternate; violation repeats; removed alternates
// [R14] Disabled pins quiet; counters keep running
`timescale 1ns/100ps
`default_nettype none
module cctx_top
  import cctx_pkg::*;
(
  input wire logic aclk,
  input wire logic aresetn,
  // AXI4-Lite slave
  input wire logic [ADDR_W-1:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [ADDR_W-1:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  // Selected reference state
  input wire logic ref_is_cc_input,
  input wire logic ref_8k_present,
  input wire logic ref_400_present,
  input wire logic ref_bpv_pulse,
  input wire logic ref_removed_pulse,
  // Composite clock output pair
  output logic cc_tx_pos_pin,
  output logic cc_tx_pos_oe,
  output logic cc_tx_neg_pin,
  output logic cc_tx_neg_oe
);
  // ==========================================================
  // Control register
  logic [3:0] ctrl_reg;          // Software control bits
  logic cc_tx_enable_bit;        // Output enable
  logic cc_tx_duty_select;       // 1 = 5/8 duty
  logic cc_tx_suppress_8k;       // Drop all violations
  logic cc_tx_400hz_enable;      // Drop one violation in twenty

  assign cc_tx_enable_bit = ctrl_reg[CTRL_EN_BIT];
  assign cc_tx_duty_select = ctrl_reg[CTRL_DUTY_BIT];
  assign cc_tx_suppress_8k = ctrl_reg[CTRL_NO8_BIT];
  assign cc_tx_400hz_enable = ctrl_reg[CTRL_400_BIT];

  // ==========================================================
  // AXI4-Lite write path
  // Address and data are taken together; this avoids holding a lone half
  logic wr_fire;                 // Write taken this cycle
  logic wr_ctrl;                 // Write hits the control register
  logic wr_hit;                  // Write hits a mapped register
  logic bvalid_reg;
  logic [1:0] bresp_reg;

  assign wr_fire = s_axi_awvalid && s_axi_wvalid && !bvalid_reg;
  assign wr_ctrl = wr_fire && (s_axi_awaddr == ADDR_CTRL);
  assign wr_hit = (s_axi_awaddr == ADDR_CTRL) || (s_axi_awaddr == ADDR_STATUS);
  assign s_axi_awready = wr_fire;
  assign s_axi_wready = wr_fire;
  assign s_axi_bvalid = bvalid_reg;
  assign s_axi_bresp = bresp_reg;

  // Control register load; only byte lane 0 holds bits
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      ctrl_reg <= CTRL_RST;
    end else if (wr_ctrl && s_axi_wstrb[0]) begin
      ctrl_reg <= s_axi_wdata[3:0]; // R2
    end
  end

  // Write response; the status register is read-only and ignores writes
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      bvalid_reg <= 1'b0;
      bresp_reg <= RESP_OKAY;
    end else if (wr_fire) begin
      bvalid_reg <= 1'b1;
      bresp_reg <= wr_hit ? RESP_OKAY : RESP_SLVERR;
    end else if (s_axi_bready) begin
      bvalid_reg <= 1'b0;
    end
  end

  // ==========================================================
  // AXI4-Lite read path
  logic rd_fire;                 // Read address taken
  logic rvalid_reg;
  logic [1:0] rresp_reg;
  logic [31:0] rdata_reg;
  logic [31:0] rd_mux;           // Read data selection
  logic [31:0] status_word;      // Live block state

  assign rd_fire = s_axi_arvalid && !rvalid_reg;
  assign s_axi_arready = !rvalid_reg;
  assign s_axi_rvalid = rvalid_reg;
  assign s_axi_rresp = rresp_reg;
  assign s_axi_rdata = rdata_reg;
  assign rd_mux = (s_axi_araddr == ADDR_CTRL) ? {28'h0, ctrl_reg} :
    (s_axi_araddr == ADDR_STATUS) ? status_word : 32'h0;

  // Read data and response registers
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      rvalid_reg <= 1'b0;
      rresp_reg <= RESP_OKAY;
      rdata_reg <= 32'h0;
    end else if (rd_fire) begin
      rvalid_reg <= 1'b1;
      rdata_reg <= rd_mux;
      rresp_reg <= ((s_axi_araddr == ADDR_CTRL) || (s_axi_araddr == ADDR_STATUS)) ?
        RESP_OKAY : RESP_SLVERR;
    end else if (s_axi_rready) begin
      rvalid_reg <= 1'b0;
    end
  end

  // ==========================================================
  // Reference alignment
  // Only a composite input whose component is present may steer timing
  logic align_8k;                // Pulse: realign to reference violation
  logic align_400;               // Pulse: realign to reference removal
  cctx_if u_if();

  assign align_8k = ref_bpv_pulse && ref_is_cc_input && ref_8k_present; // R7
  assign align_400 = ref_removed_pulse && ref_is_cc_input && ref_400_present; // R9
  assign u_if.restart = align_8k || align_400;

  cctx_bit_timer u_timer (
    .aclk(aclk),
    .aresetn(aresetn),
    .duty_58(cc_tx_duty_select),
    .tif(u_if.timer_mp)
  );

  cctx_frame_seq u_seq (
    .aclk(aclk),
    .aresetn(aresetn),
    .align_8k(align_8k),
    .align_400(align_400),
    .sif(u_if.seq_mp)
  );

  // ==========================================================
  // AMI encoder
  logic bpv_now;                 // The starting bit repeats polarity
  logic mark_pos_reg;            // Polarity of the current mark, 1 = positive
  logic mark_pos_next;
  logic cur_pos;                 // Polarity on the pins; a bit start shows the new one
  logic bpv_reg;                 // Current bit is a violation
  logic pos_reg;
  logic neg_reg;

  // Removal only matters while violations exist at all
  assign bpv_now = u_if.viol_slot && !cc_tx_suppress_8k && // R6
    !(u_if.removed_slot && cc_tx_400hz_enable); // R8 R11
  // A violation keeps the last polarity, every other mark flips it
  assign mark_pos_next = bpv_now ? mark_pos_reg : !mark_pos_reg; // R13
  // Without the look-ahead the old polarity would flash for a cycle at each bit start
  assign cur_pos = u_if.bit_start ? mark_pos_next : mark_pos_reg; // R1 R13

  // Polarity runs even while disabled so re-enable lands mid-pattern cleanly
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      mark_pos_reg <= 1'b0;
      bpv_reg <= 1'b0;
    end else if (u_if.bit_start) begin
      mark_pos_reg <= mark_pos_next; // R14
      bpv_reg <= bpv_now;
    end
  end

  // Pin drive; every bit is a mark, returning to zero after its window
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      pos_reg <= 1'b0;
      neg_reg <= 1'b0;
    end else begin
      pos_reg <= cc_tx_enable_bit && u_if.mark_on && cur_pos; // R1 R14
      neg_reg <= cc_tx_enable_bit && u_if.mark_on && !cur_pos; // R1 R14
    end
  end

  assign cc_tx_pos_pin = pos_reg;
  assign cc_tx_neg_pin = neg_reg;
  // Both enables come from the one bit
  assign cc_tx_pos_oe = cc_tx_enable_bit; // R2
  assign cc_tx_neg_oe = cc_tx_enable_bit; // R2

  // ==========================================================
  // Status
  logic align8_seen_reg;         // Sticky: set by any reference restart, cleared only by reset
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      align8_seen_reg <= 1'b0;
    end else if (u_if.restart) begin
      align8_seen_reg <= 1'b1;
    end
  end
  assign status_word = {24'h0, u_if.bit_idx, align8_seen_reg,
    ref_is_cc_input && ref_400_present, ref_is_cc_input && ref_8k_present,
    bpv_reg, mark_pos_reg};

  // ==========================================================
  // Checks
  logic [CNT_W-1:0] mark_len;    // Cycles the line has been high
  logic [CNT_W-1:0] gap_len;     // Cycles since the last bit start
  logic [3:0] since_bpv;         // Bits since the last violation slot
  logic [1:0] en_bits;           // Bit starts seen while enabled, saturating
  logic rst_in_bit;              // A restart fell inside the current bit
  logic last_neg;                // Previous pin pulse was negative
  logic line_hi;
  logic [CNT_W-1:0] exp_width;

  assign line_hi = pos_reg || neg_reg;
  assign exp_width = cc_tx_duty_select ? CNT_W'(FIVE8_CYC) : CNT_W'(HALF_CYC);

  // Helper counters that only the checks read
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      mark_len <= '0;
      // The first bit start after reset counts as on time
      gap_len <= CNT_W'(BIT_CYC);
      since_bpv <= '0;
      rst_in_bit <= 1'b0;
      last_neg <= 1'b0;
      en_bits <= 2'h0;
    end else begin
      mark_len <= line_hi ? mark_len + CNT_W'(1) : '0;
      gap_len <= u_if.bit_start ? CNT_W'(1) : gap_len + CNT_W'(1);
      if (!cc_tx_enable_bit) begin
        en_bits <= 2'h0;
      end else if (u_if.bit_start && en_bits != 2'h3) begin
        en_bits <= en_bits + 2'h1;
      end
      if (u_if.bit_start) begin
        since_bpv <= u_if.viol_slot ? 4'h0 : since_bpv + 4'h1;
        rst_in_bit <= 1'b0;
      end else if (u_if.restart) begin
        rst_in_bit <= 1'b1;
      end
      if ($fell(pos_reg)) begin
        last_neg <= 1'b0;
      end else if ($fell(neg_reg)) begin
        last_neg <= 1'b1;
      end
    end
  end

  property p_pins_exclusive;
    @(posedge aclk) disable iff (!aresetn) !(cc_tx_pos_pin && cc_tx_neg_pin);
  endproperty
  a_pins_exclusive: assert property (p_pins_exclusive) // R1
    else $error("both output pins high");

  property p_oe_follows_write;
    @(posedge aclk) disable iff (!aresetn) (wr_ctrl && s_axi_wstrb[0]) |=>
      (cc_tx_pos_oe == $past(s_axi_wdata[CTRL_EN_BIT])) && (cc_tx_neg_oe == cc_tx_pos_oe);
  endproperty
  a_oe_follows_write: assert property (p_oe_follows_write) // R2
    else $error("output enables do not follow control write");

  property p_mark_width;
    @(posedge aclk) disable iff (!aresetn)
      ($fell(line_hi) && !rst_in_bit && $stable(cc_tx_duty_select) && cc_tx_enable_bit &&
      en_bits != 2'h0) |-> (mark_len == exp_width);
  endproperty
  a_mark_width: assert property (p_mark_width) // R3
    else $error("mark width differs from duty setting");

  property p_bit_period;
    @(posedge aclk) disable iff (!aresetn)
      (u_if.bit_start && !$past(u_if.restart)) |-> (gap_len == CNT_W'(BIT_CYC));
  endproperty
  a_bit_period: assert property (p_bit_period) // R4
    else $error("bit period is not the line rate");

  property p_disabled_quiet;
    @(posedge aclk) disable iff (!aresetn) !cc_tx_enable_bit |=> !line_hi;
  endproperty
  a_disabled_quiet: assert property (p_disabled_quiet) // R14
    else $error("pin pulse while output disabled");

  property p_alternate;
    @(posedge aclk) disable iff (!aresetn)
      ($rose(pos_reg) && !bpv_reg && en_bits >= 2'h2) |-> last_neg;
  endproperty
  a_alternate: assert property (p_alternate) // R13 R5
    else $error("positive mark did not follow a negative one");

  property p_bpv_spacing;
    @(posedge aclk) disable iff (!aresetn)
      (u_if.bit_start && bpv_now && !rst_in_bit)
      |-> (since_bpv == 4'h7);
  endproperty
  a_bpv_spacing: assert property (p_bpv_spacing) // R12
    else $error("violations not eight bits apart");

  property p_suppress;
    @(posedge aclk) disable iff (!aresetn)
      (u_if.bit_start && cc_tx_suppress_8k) |=> (mark_pos_reg != $past(mark_pos_reg));
  endproperty
  a_suppress: assert property (p_suppress) // R6 R11
    else $error("violation sent while suppressed");

  property p_removal;
    @(posedge aclk) disable iff (!aresetn)
      (u_if.bit_start && u_if.removed_slot && cc_tx_400hz_enable) |=> !bpv_reg;
  endproperty
  a_removal: assert property (p_removal) // R8
    else $error("400 Hz removal slot carried a violation");

  property p_align_8k;
    @(posedge aclk) disable iff (!aresetn)
      (align_8k && !align_400) |=> (u_if.bit_start && u_if.viol_slot);
  endproperty
  a_align_8k: assert property (p_align_8k) // R7
    else $error("violation not aligned to reference");

  property p_align_400;
    @(posedge aclk) disable iff (!aresetn) align_400 |=> (u_if.bit_start && u_if.removed_slot);
  endproperty
  a_align_400: assert property (p_align_400) // R9
    else $error("400 Hz pattern not aligned to reference");
endmodule : cctx_top
`default_nettype wire

/* File: cctx_line_model.sv */
/*
  Line-side model of the transformer that takes the composite clock
  pin pair: decodes marks, their polarity and their widths.
  Assumes the pins are registered on aclk and gated by their enables.
*/
`timescale 1ns/100ps
`default_nettype none
module cctx_line_model (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic pos_pin,
  input wire logic pos_oe,
  input wire logic neg_pin,
  input wire logic neg_oe,
  output logic [15:0] mark_cnt,
  output logic last_pos,
  output logic prev_pos,
  output logic [15:0] last_len,
  output logic overlap
);
  // ==========================================================
  // Winding decode
  logic pos_line; // Positive half driven
  logic neg_line; // Negative half driven
  logic on_line; // Any mark on the line
  logic was_on; // Mark seen at the last edge
  logic [15:0] run_len; // Width of the mark now on the line
  assign pos_line = pos_pin & pos_oe;
  assign neg_line = neg_pin & neg_oe;
  assign on_line = pos_line | neg_line;
  // Marks need a space between them, so a polarity flip with no gap is missed
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      mark_cnt <= 16'h0000;
      last_pos <= 1'b0;
      prev_pos <= 1'b0;
      last_len <= 16'h0000;
      overlap <= 1'b0;
      was_on <= 1'b0;
      run_len <= 16'h0000;
    end else begin
      // Both halves at once is never a valid AMI symbol
      if (pos_line && neg_line) begin
        overlap <= 1'b1;
      end
      if (on_line && !was_on) begin
        mark_cnt <= mark_cnt + 16'h0001;
        prev_pos <= last_pos;
        last_pos <= pos_line;
        run_len <= 16'h0001;
      end else if (on_line) begin
        run_len <= run_len + 16'h0001;
      end
      // Return to zero closes the mark
      if (!on_line && was_on) begin
        last_len <= run_len;
      end
      was_on <= on_line;
    end
  end
endmodule : cctx_line_model
`default_nettype wire

/* File: tb_top.sv */
/*
  Testbench of the composite clock transmitter: register rows, then
  line code, duty, alignment, suppression and enable cases.
  Assumes the line model decodes the pin pair.
*/
`timescale 1ns/100ps
`default_nettype none
module tb_top
  import cctx_pkg::*;
;
  // ==========================================================
  // Signals
  typedef struct packed {
    logic wr;
    logic [3:0] addr;
    logic [31:0] data;
    logic [3:0] strb;
    logic [1:0] resp;
    logic [31:0] rdata;
  } cctx_row_t;
  logic aclk = 1'b0;
  logic aresetn = 1'b0;
  logic [3:0] awaddr, araddr, wstrb;
  logic [31:0] wdata, rdata, data;
  logic awvalid, awready, wvalid, wready, bvalid, bready;
  logic arvalid, arready, rvalid, rready;
  logic [1:0] bresp, rresp, resp;
  logic is_cc, has_8k, has_400, bpv_p, rem_p;
  logic pos, pos_oe, neg, neg_oe, last_pos, prev_pos, overlap;
  logic [15:0] mark_cnt, last_len;
  int n_errors = 0;
  int checked = 0;
  int n;
  int hi;
  cctx_row_t rows [11];
  // Clock, 5 ns period
  always #2.5 aclk = ~aclk;
  cctx_top dut (.aclk(aclk), .aresetn(aresetn), .s_axi_awaddr(awaddr),
    .s_axi_awvalid(awvalid), .s_axi_awready(awready), .s_axi_wdata(wdata),
    .s_axi_wstrb(wstrb), .s_axi_wvalid(wvalid), .s_axi_wready(wready),
    .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
    .s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(arready),
    .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid),
    .s_axi_rready(rready), .ref_is_cc_input(is_cc), .ref_8k_present(has_8k),
    .ref_400_present(has_400), .ref_bpv_pulse(bpv_p), .ref_removed_pulse(rem_p),
    .cc_tx_pos_pin(pos), .cc_tx_pos_oe(pos_oe), .cc_tx_neg_pin(neg),
    .cc_tx_neg_oe(neg_oe));
  cctx_line_model model (.aclk(aclk), .aresetn(aresetn), .pos_pin(pos),
    .pos_oe(pos_oe), .neg_pin(neg), .neg_oe(neg_oe), .mark_cnt(mark_cnt),
    .last_pos(last_pos), .prev_pos(prev_pos), .last_len(last_len),
    .overlap(overlap));
  // ==========================================================
  // Tasks
  task automatic check(input string what, input logic [31:0] seen,
    input logic [31:0] exp);
    checked++;
    if (seen !== exp) begin
      n_errors++;
      $display("wrong value %s expected %h seen %h", what, exp, seen);
    end
  endtask : check
  task automatic summarize();
    $display("checked %0d n_errors %0d", checked, n_errors);
    if (n_errors == 0 && checked > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask : summarize
  // Address and data offered together, each held until taken
  task automatic axi_write(input logic [3:0] a, input logic [31:0] d,
    input logic [3:0] s, output logic [1:0] r);
    @(posedge aclk);
    awaddr <= a;
    wdata <= d;
    wstrb <= s;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    do @(posedge aclk); while (!(awready === 1'b1 && wready === 1'b1));
    awvalid <= 1'b0;
    wvalid <= 1'b0;
    do @(posedge aclk); while (bvalid !== 1'b1);
    r = bresp;
    bready <= 1'b0;
  endtask : axi_write
  task automatic axi_read(input logic [3:0] a, output logic [31:0] d,
    output logic [1:0] r);
    @(posedge aclk);
    araddr <= a;
    arvalid <= 1'b1;
    rready <= 1'b1;
    do @(posedge aclk); while (arready !== 1'b1);
    arvalid <= 1'b0;
    do @(posedge aclk); while (rvalid !== 1'b1);
    d = rdata;
    r = rresp;
    rready <= 1'b0;
  endtask : axi_read
  // Waits for the next mark start; gives the cycles waited
  task automatic wait_mark(output int w);
    logic [15:0] start;
    start = mark_cnt;
    w = 0;
    while (mark_cnt === start && w < 3300) begin
      @(posedge aclk);
      w++;
    end
    check("mark due", w < 3300, 1'b1);
  endtask : wait_mark
  // Reference pulse in a space, so a repeated polarity still shows an edge
  task automatic align(input logic use_400, input logic exp_same);
    logic [15:0] start;
    int w;
    while (pos === 1'b1 || neg === 1'b1) @(posedge aclk);
    start = mark_cnt;
    if (use_400) rem_p <= 1'b1;
    else bpv_p <= 1'b1;
    @(posedge aclk);
    rem_p <= 1'b0;
    bpv_p <= 1'b0;
    w = 0;
    while (mark_cnt === start && w < 8) begin
      @(posedge aclk);
      w++;
    end
    check("align delay", w <= 5, 1'b1);
    check("repeat", last_pos === prev_pos, exp_same);
  endtask : align
  // ==========================================================
  // Watchdog, well past the expected 45k cycles
  initial begin
    repeat (90000) @(posedge aclk);
    n_errors++;
    summarize();
  end
  // ==========================================================
  // Main sequence
  initial begin
    {awaddr, araddr, wstrb, wdata} = '0;
    {awvalid, wvalid, bready, arvalid, rready, bpv_p, rem_p} = '0;
    {is_cc, has_8k, has_400} = 3'h7;
    rows[0] = '{1'b0, 4'h0, 32'h0, 4'h0, RESP_OKAY, 32'h0};
    rows[1] = '{1'b1, 4'h0, 32'h5, 4'hF, RESP_OKAY, 32'h0};
    rows[2] = '{1'b0, 4'h0, 32'h0, 4'h0, RESP_OKAY, 32'h5};
    rows[3] = '{1'b1, 4'h4, 32'hFF, 4'hF, RESP_OKAY, 32'h0};
    rows[4] = '{1'b0, 4'h0, 32'h0, 4'h0, RESP_OKAY, 32'h5};
    rows[5] = '{1'b1, 4'h0, 32'hA, 4'h0, RESP_OKAY, 32'h0};
    rows[6] = '{1'b0, 4'h0, 32'h0, 4'h0, RESP_OKAY, 32'h5};
    rows[7] = '{1'b1, 4'h8, 32'h1, 4'hF, RESP_SLVERR, 32'h0};
    rows[8] = '{1'b0, 4'h8, 32'h0, 4'h0, RESP_SLVERR, 32'h0};
    rows[9] = '{1'b1, 4'h0, 32'h5, 4'hF, RESP_OKAY, 32'h0};
    rows[10] = '{1'b0, 4'h0, 32'h0, 4'h0, RESP_OKAY, 32'h5};
    repeat (3) @(posedge aclk);
    aresetn <= 1'b1;
    @(posedge aclk);
    check("pins at reset", {pos_oe, neg_oe, pos, neg}, 4'h0);
    foreach (rows[i]) begin
      if (rows[i].wr) begin
        axi_write(rows[i].addr, rows[i].data, rows[i].strb, resp);
      end else begin
        axi_read(rows[i].addr, data, resp);
        check("rdata", data, rows[i].rdata);
      end
      check("resp", resp, rows[i].resp);
    end
    check("enables on", {pos_oe, neg_oe}, 2'h3);
    // Half duty, suppressed so every mark alternates
    repeat (3) wait_mark(n);
    check("bit period", n, BIT_CYC);
    check("half mark", last_len, HALF_CYC);
    check("alternate", last_pos !== prev_pos, 1'b1);
    // 5/8 duty, violation placed by the reference, then one full frame
    axi_write(4'h0, 32'h3, 4'hF, resp);
    align(1'b0, 1'b1);
    for (int i = 0; i < 8; i++) begin
      wait_mark(n);
      check("bit period", n, BIT_CYC);
      check("five8 mark", last_len, FIVE8_CYC);
      check("frame", last_pos === prev_pos, i == 7);
    end
    axi_write(4'h0, 32'h7, 4'hF, resp);
    align(1'b0, 1'b0);
    axi_write(4'h0, 32'hB, 4'hF, resp);
    align(1'b1, 1'b0);
    axi_write(4'h0, 32'hF, 4'hF, resp);
    align(1'b0, 1'b0);
    // Disabled: both enables low, no pulse for a whole bit
    axi_write(4'h0, 32'h2, 4'hF, resp);
    @(posedge aclk);
    check("enables off", {pos_oe, neg_oe}, 2'h0);
    hi = 0;
    repeat (3200) begin
      @(posedge aclk);
      hi += int'(pos | neg);
    end
    check("quiet", hi, 0);
    axi_write(4'h0, 32'h3, 4'hF, resp);
    wait_mark(n);
    check("overlap", overlap, 1'b0);
    axi_read(ADDR_STATUS, data, resp);
    check("status", data[4:2], 3'h7);
    // Reset in mid-mark: pins, enables and sticky status clear at once
    aresetn <= 1'b0;
    @(posedge aclk);
    aresetn <= 1'b1;
    @(posedge aclk);
    check("pins after reset", {pos_oe, neg_oe, pos, neg}, 4'h0);
    axi_read(ADDR_STATUS, data, resp);
    check("status after reset", data[4:2], 3'h3);
    summarize();
  end
endmodule : tb_top
`default_nettype wire
